// ### inc/dml_regs.svh
// Constants of the diagnostic message log: register offsets, fields, codes, timing.
// Assumes inclusion by bare name from the package and the design module.
// Summary of operation
// - Every record opens with fixed class code.
// - Flags bits 0-3 hold severity 0/1/2.
// - Flags bit 4 marks local timestamp.
// - Flags bits 8-15 count parameters; 5-7 zero.
// - Record carries a 16-bit text reference.
// - Record carries 64-bit nanosecond power-on timestamp.
// - Record ends with 16-byte parameter area.
// - Each parameter preceded by type descriptor.
// - Value follows descriptor, sized by its type.
// - Current local timestamp readable separately.
// - New stored record sets pending indicator.
// - Whole-object read returns every history entry.
// - Pending indicator clears after history read.
// - Enabled: each record also sent as emergency.
// - Sixty-four records, oldest overwritten when full.
// - Read-only pointer holds newest record subindex.
`ifndef DML_REGS_SVH
`define DML_REGS_SVH
// ****************************************************************
// Register offsets (byte addresses).
// ****************************************************************
`define DML_OFS_MAX      12'h000
`define DML_OFS_NEWEST   12'h004
`define DML_OFS_ACK      12'h008
`define DML_OFS_NEWAVAIL 12'h00C
`define DML_OFS_EMCY     12'h010
`define DML_OFS_TS_LO    12'h014
`define DML_OFS_TS_HI    12'h018
`define DML_OFS_IRQ_STAT 12'h01C
`define DML_OFS_IRQ_MASK 12'h020
`define DML_OFS_WHOLE    12'h024
`define DML_REC_SEL_BIT  11
// ****************************************************************
// Record layout and codes.
// ****************************************************************
`define DML_CLASS_CODE   32'h0000E000
`define DML_SEV_INFO     4'h0
`define DML_SEV_WARN     4'h1
`define DML_SEV_ERROR    4'h2
`define DML_FLAG_LOCAL   1'h1
`define DML_SUB_BASE     8'h06
`define DML_EMCY_ON      16'h0001
`define DML_MAX_PARAMS   8'h02
`define DML_AREA_BYTES   5'h10
`define DML_DESC_BYTES   5'h02
`define DML_TYP_BOOL     12'h001
`define DML_TYP_INT8     12'h002
`define DML_TYP_INT16    12'h003
`define DML_TYP_INT32    12'h004
`define DML_TYP_UINT8    12'h005
`define DML_TYP_UINT16   12'h006
`define DML_TYP_UINT32   12'h007
`define DML_TYP_REAL32   12'h008
`define DML_TYP_REAL64   12'h011
`define DML_TYP_INT64    12'h015
`define DML_TYP_UINT64   12'h01B
// ****************************************************************
// Timing.
// ****************************************************************
`define DML_CLK_HZ       1000000000 / 40
`define DML_NS_PER_S     1000000000
`define DML_NS_STEP      (`DML_NS_PER_S / (`DML_CLK_HZ))
// Interrupt bits.
`define DML_IRQ_NEW      0
`define DML_IRQ_WRAP     1
`define DML_IRQ_DONE     2
`endif

// ### inc/dml_pkg.sv
// Types of the diagnostic message log.
// Assumes the constants header is reachable on the include path.
`include "dml_regs.svh"
package dml_pkg;
	typedef logic [255:0] dml_rec_t;
	typedef logic [2:0]   dml_irq_t;
	typedef enum logic [1:0] {
		DML_IDLE   = 2'b01,
		DML_STREAM = 2'b10
	} dml_state_t;
endpackage

// ### hw/dml_log.sv
// Diagnostic message log: builds 32-byte records, stores a ring of them, registers.
// Assumes events and register strobes are synchronous single-cycle pulses.
`timescale 1ns/1ps
`include "dml_regs.svh"
module dml_log #(
	parameter int DEPTH = 64
) (
	input  wire logic           clock_in,
	input  wire logic           rst_b_in,
	input  wire logic           ev_valid_in,
	input  wire logic [3:0]     ev_severity_in,
	input  wire logic [15:0]    ev_text_in,
	input  wire logic [1:0]     ev_pcount_in,
	input  wire logic [11:0]    ev_p1_type_in,
	input  wire logic [63:0]    ev_p1_value_in,
	input  wire logic [11:0]    ev_p2_type_in,
	input  wire logic [63:0]    ev_p2_value_in,
	input  wire logic [11:0]    reg_addr_in,
	input  wire logic [31:0]    reg_wdata_in,
	input  wire logic           reg_wr_in,
	input  wire logic           reg_rd_in,
	output logic      [31:0]    reg_rdata_out,
	output logic                pending_out,
	output logic                emcy_valid_out,
	output dml_pkg::dml_rec_t   emcy_record_out,
	output logic                irq_out
);
	import dml_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int SW = AW + 3;

	// ****************************************************************
	// Record assembly
	// ****************************************************************

	// Byte size implied by a parameter type code; unknown codes carry no value.
	function automatic logic [4:0] dml_psize(input logic [11:0] t);
		logic [4:0] s;
		s = 5'h00;
		case (t)
			`DML_TYP_BOOL, `DML_TYP_INT8, `DML_TYP_UINT8:     s = 5'h01;
			`DML_TYP_INT16, `DML_TYP_UINT16:                  s = 5'h02;
			`DML_TYP_INT32, `DML_TYP_UINT32, `DML_TYP_REAL32: s = 5'h04;
			`DML_TYP_REAL64, `DML_TYP_INT64, `DML_TYP_UINT64: s = 5'h08;
			default:                                          s = 5'h00;
		endcase
		return s;
	endfunction

	// Keeps only the low bytes of a value that its type occupies.
	function automatic logic [63:0] dml_mask(input logic [4:0] s);
		logic [63:0] m;
		m = (s == 5'h08) ? 64'hFFFFFFFFFFFFFFFF : ((64'h1 << {s, 3'h0}) - 64'h1);
		return m;
	endfunction

	logic [63:0]  ts;
	dml_rec_t     mem [DEPTH];
	logic [AW-1:0] wptr;
	logic         full;
	logic [7:0]   newest;
	logic [7:0]   ack;
	logic [15:0]  emcy_flags;
	logic [31:0]  ts_hi_snap;
	dml_irq_t     irq_stat;
	dml_irq_t     irq_mask;
	dml_state_t   state;
	logic [SW-1:0] sptr;

	// Severity clamp, size and fit checks for the parameter area.
	wire [3:0]   sev_eff = (ev_severity_in > `DML_SEV_ERROR) ? `DML_SEV_ERROR
	                       : ev_severity_in;
	wire [4:0]   p1_size = dml_psize(ev_p1_type_in);
	wire [4:0]   p2_size = dml_psize(ev_p2_type_in);
	wire [4:0]   both_sz = 5'(`DML_DESC_BYTES + `DML_DESC_BYTES + p1_size + p2_size);
	wire         p2_fits = (both_sz <= `DML_AREA_BYTES);
	wire [7:0]   pcount  = (ev_pcount_in == 2'h0) ? 8'h00
	                       : ((ev_pcount_in == 2'h1) || !p2_fits) ? 8'h01 : 8'h02;
	wire [15:0]  desc1   = {4'h0, ev_p1_type_in};
	wire [15:0]  desc2   = {4'h0, ev_p2_type_in};
	wire [127:0] blk1    = {112'h0, desc1} | ({64'h0, ev_p1_value_in & dml_mask(p1_size)} << 16);
	wire [127:0] blk2    = {112'h0, desc2} | ({64'h0, ev_p2_value_in & dml_mask(p2_size)} << 16);
	wire [6:0]   p2_shift = 7'({(p1_size + `DML_DESC_BYTES), 3'h0});
	// Descriptor then value, second pair packed right after the first.
	wire [127:0] area    = ((pcount != 8'h00) ? blk1 : 128'h0)
	                       | ((pcount == 8'h02) ? (blk2 << p2_shift) : 128'h0);
	wire [15:0]  flags   = {pcount, 3'h0, `DML_FLAG_LOCAL, sev_eff};
	// Class code, flags, text reference, timestamp, parameter area, low byte first.
	wire dml_rec_t rec   = {area, ts, ev_text_in, flags, `DML_CLASS_CODE};

	// ****************************************************************
	// Register decode
	// ****************************************************************

	// Address decode for writes and reads.
	wire         hit_rec   = reg_addr_in[`DML_REC_SEL_BIT];
	wire [AW-1:0] rec_idx  = reg_addr_in[AW+4:5];
	wire [2:0]   rec_word  = reg_addr_in[4:2];
	wire         wr_ack    = reg_wr_in && (reg_addr_in == `DML_OFS_ACK);
	wire         wr_emcy   = reg_wr_in && (reg_addr_in == `DML_OFS_EMCY);
	wire         wr_istat  = reg_wr_in && (reg_addr_in == `DML_OFS_IRQ_STAT);
	wire         wr_imask  = reg_wr_in && (reg_addr_in == `DML_OFS_IRQ_MASK);
	wire         wr_whole  = reg_wr_in && (reg_addr_in == `DML_OFS_WHOLE);
	wire         rd_ts_lo  = reg_rd_in && (reg_addr_in == `DML_OFS_TS_LO);
	wire         rd_whole  = reg_rd_in && (reg_addr_in == `DML_OFS_WHOLE);
	wire         streaming = (state == DML_STREAM);
	wire         step      = rd_whole && streaming;
	wire         last_word = (sptr == {SW{1'b1}});
	wire         done      = step && last_word;
	wire         emcy_en   = (emcy_flags == `DML_EMCY_ON);
	wire [31:0]  rec_data  = mem[rec_idx][{rec_word, 5'h00} +: 32];
	wire [31:0]  str_data  = streaming ? mem[sptr[SW-1:3]][{sptr[2:0], 5'h00} +: 32] : 32'h0;
	wire dml_irq_t irq_ev  = {done, ev_valid_in && full, ev_valid_in};

	// Read multiplexer; unmapped addresses read as zero.
	wire [31:0]  rd_mux =
		hit_rec                          ? rec_data :
		(reg_addr_in == `DML_OFS_MAX)      ? 32'(DEPTH) :
		(reg_addr_in == `DML_OFS_NEWEST)   ? {24'h0, newest} :
		(reg_addr_in == `DML_OFS_ACK)      ? {24'h0, ack} :
		(reg_addr_in == `DML_OFS_NEWAVAIL) ? {31'h0, pending_out} :
		(reg_addr_in == `DML_OFS_EMCY)     ? {16'h0, emcy_flags} :
		(reg_addr_in == `DML_OFS_TS_LO)    ? ts[31:0] :
		(reg_addr_in == `DML_OFS_TS_HI)    ? ts_hi_snap :
		(reg_addr_in == `DML_OFS_IRQ_STAT) ? {29'h0, irq_stat} :
		(reg_addr_in == `DML_OFS_IRQ_MASK) ? {29'h0, irq_mask} :
		(reg_addr_in == `DML_OFS_WHOLE)    ? str_data : 32'h0;

	// ****************************************************************
	// State
	// ****************************************************************

	// Free-running nanosecond time base since reset release.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ts <= 64'h0;
		end else begin
			ts <= ts + 64'(`DML_NS_STEP);
		end
	end

	// History ring; a full ring overwrites its oldest entry.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
			wptr   <= '0;
			full   <= 1'b0;
			newest <= 8'h00;
		end else if (ev_valid_in) begin
			mem[wptr] <= rec;
			wptr      <= wptr + AW'(1);
			full      <= full || (wptr == AW'(DEPTH - 1));
			newest    <= `DML_SUB_BASE + 8'(wptr);
		end
	end

	// Pending indicator: a new record wins over a finished read.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pending_out <= 1'b0;
		end else if (ev_valid_in) begin
			pending_out <= 1'b1;
		end else if (done) begin
			pending_out <= 1'b0;
		end
	end

	// Whole-object stream: a write restarts it, each read steps one word.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= DML_IDLE;
			sptr  <= '0;
		end else begin
			case (state)
				DML_IDLE: begin
					if (wr_whole) begin
						state <= DML_STREAM;
						sptr  <= '0;
					end
				end
				DML_STREAM: begin
					if (wr_whole) begin
						sptr <= '0;
					end else if (step) begin
						sptr  <= sptr + SW'(1);
						state <= last_word ? DML_IDLE : DML_STREAM;
					end
				end
				default: state <= DML_IDLE;
			endcase
		end
	end

	// Software registers, timestamp snapshot and read data.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ack           <= 8'h00;
			emcy_flags    <= 16'h0000;
			ts_hi_snap    <= 32'h0;
			irq_mask      <= '0;
			reg_rdata_out <= 32'h0;
		end else begin
			ack           <= wr_ack ? reg_wdata_in[7:0] : ack;
			emcy_flags    <= wr_emcy ? reg_wdata_in[15:0] : emcy_flags;
			ts_hi_snap    <= rd_ts_lo ? ts[63:32] : ts_hi_snap;
			irq_mask      <= wr_imask ? reg_wdata_in[2:0] : irq_mask;
			reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0;
		end
	end

	// Sticky interrupt status, write one to clear, a new event wins.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			irq_stat <= '0;
			irq_out  <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~(wr_istat ? reg_wdata_in[2:0] : 3'h0)) | irq_ev;
			irq_out  <= |(((irq_stat & ~(wr_istat ? reg_wdata_in[2:0] : 3'h0)) | irq_ev)
			              & irq_mask);
		end
	end

	// Emergency copy of each record while notification is enabled.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			emcy_valid_out  <= 1'b0;
			emcy_record_out <= '0;
		end else begin
			emcy_valid_out  <= ev_valid_in && emcy_en;
			emcy_record_out <= (ev_valid_in && emcy_en) ? rec : emcy_record_out;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************

	default clocking dml_cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	sequence dml_seq_event;
		ev_valid_in;
	endsequence
	sequence dml_seq_stored;
		##1 1'b1;
	endsequence

	chk_class_code: assert property (dml_seq_event |-> dml_seq_stored ##0
		mem[$past(wptr)][31:0] == `DML_CLASS_CODE) else $error("Class code wrong.");
	chk_severity_code: assert property (dml_seq_event |=>
		mem[$past(wptr)][35:32] <= `DML_SEV_ERROR) else $error("Reserved severity.");
	chk_local_flag: assert property (dml_seq_event |=> mem[$past(wptr)][36])
		else $error("Local timestamp flag clear.");
	chk_reserved_zero: assert property (dml_seq_event |=>
		mem[$past(wptr)][39:37] == 3'h0 && mem[$past(wptr)][143:140] == 4'h0)
		else $error("Reserved bits set.");
	chk_text_kept: assert property (dml_seq_event |=>
		mem[$past(wptr)][63:48] == $past(ev_text_in)) else $error("Text reference lost.");
	chk_time_step: assert property (ts != 64'h0 |=> ts == $past(ts) + 64'(`DML_NS_STEP))
		else $error("Timestamp step wrong.");
	chk_pending_set: assert property (dml_seq_event |=> pending_out [*1])
		else $error("Pending not set.");
	chk_pending_clear: assert property (done && !ev_valid_in |=> !pending_out)
		else $error("Pending not cleared.");
	chk_newest_index: assert property (dml_seq_event |=>
		newest == `DML_SUB_BASE + 8'($past(wptr))) else $error("Newest pointer wrong.");
	chk_ring_wrap: assert property ((dml_seq_event and (wptr == AW'(DEPTH - 1))) |=>
		wptr == '0 && full) else $error("Ring did not wrap.");
	chk_emcy_send: assert property ((dml_seq_event and emcy_en) |=> emcy_valid_out
		##1 !emcy_valid_out || $past(ev_valid_in)) else $error("Emergency not sent.");

	// ****************************************************************
	// Checks on stored fields, pending, stream, emergency, read data and interrupt
	// ****************************************************************

	// The stream closes after its last word and leaves the done flag behind.
	sequence dml_seq_closed;
		(state == DML_IDLE) && irq_stat[`DML_IRQ_DONE];
	endsequence

	// The stored timestamp is the time base of the event cycle.
	chk_stamp_kept: assert property (dml_seq_event |=>
		mem[$past(wptr)][127:64] == $past(ts)) else $error("Timestamp not kept.");
	// A stored record never counts more than two parameters.
	chk_param_count: assert property (dml_seq_event |=>
		mem[$past(wptr)][47:40] <= `DML_MAX_PARAMS) else $error("Too many parameters.");
	// An event that meets a full ring flags the overwrite.
	chk_wrap_flag: assert property ((dml_seq_event and full) |=>
		irq_stat[`DML_IRQ_WRAP]) else $error("Overwrite not flagged.");

	// Pending stays up until a whole read has finished.
	chk_pending_hold: assert property (pending_out && !done |=> pending_out)
		else $error("Pending dropped early.");
	// Each stream read moves on by exactly one word.
	chk_stream_step: assert property (step && !last_word && !wr_whole |=>
		sptr == $past(sptr) + SW'(1)) else $error("Stream pointer step wrong.");
	// Reading the last word ends the stream and raises the done flag.
	chk_stream_done: assert property (done |=> dml_seq_closed)
		else $error("Stream did not close.");

	// Emergencies stay silent while notification is off.
	chk_emcy_quiet: assert property (!emcy_en |=> !emcy_valid_out)
		else $error("Emergency sent while off.");
	// Read data stand for one cycle only and fall back to zero.
	chk_read_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
		else $error("Read data not idle.");
	// The level interrupt follows the status under the mask of the cycle before.
	chk_irq_level: assert property (irq_out == |(irq_stat & $past(irq_mask)))
		else $error("Interrupt level wrong.");
endmodule

// ### test/dml_master_model.sv
// Master model driving the register port of the diagnostic message log.
// Assumes one clock and read data in the cycle after the read strobe.
`timescale 1ns/1ps
`include "dml_regs.svh"
module dml_master_model (
	input  wire logic        clock_in,
	input  wire logic [31:0] reg_rdata_in,
	output logic      [11:0] reg_addr_out,
	output logic      [31:0] reg_wdata_out,
	output logic             reg_wr_out,
	output logic             reg_rd_out
);
	// The bus starts idle with both strobes low.
	initial begin
		reg_addr_out  = 12'h000;
		reg_wdata_out = 32'h00000000;
		reg_wr_out    = 1'b0;
		reg_rd_out    = 1'b0;
	end
	// One-cycle write; address and data are inverted after release.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_addr_out  <= a;
		reg_wdata_out <= d;
		reg_wr_out    <= 1'b1;
		@(posedge clock_in);
		reg_wr_out    <= 1'b0;
		reg_addr_out  <= ~a;
		reg_wdata_out <= ~d;
	endtask
	// One-cycle read; the data are taken in the answer cycle.
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clock_in);
		reg_addr_out <= a;
		reg_rd_out   <= 1'b1;
		@(posedge clock_in);
		reg_rd_out   <= 1'b0;
		reg_addr_out <= ~a;
		#1;
		d = reg_rdata_in;
	endtask
	// Emergency enable as the startup list writes it.
	task automatic set_emcy(input logic on);
		wr(`DML_OFS_EMCY, on ? 32'h00000001 : 32'h00000002);
	endtask
	// Starts a whole-object read of the history.
	task automatic start_whole();
		wr(`DML_OFS_WHOLE, 32'h00000000);
	endtask
endmodule

// ### test/dml_log_tb_top.sv
// Self-checking bench of the diagnostic message log.
// Assumes the constants header on the include path and a 64-record ring.
`timescale 1ns/1ps
`include "dml_regs.svh"
module dml_log_tb_top;
	import dml_pkg::*;
	logic              clock_in = 1'b0;
	logic              rst_b_in = 1'b0;
	logic              ev_valid_in = 1'b0;
	logic [3:0]        ev_severity_in = 4'h0;
	logic [15:0]       ev_text_in = 16'h0000;
	logic [1:0]        ev_pcount_in = 2'h0;
	logic [11:0]       ev_p1_type_in = 12'h000;
	logic [63:0]       ev_p1_value_in = 64'h0;
	logic [11:0]       ev_p2_type_in = 12'h000;
	logic [63:0]       ev_p2_value_in = 64'h0;
	logic [11:0]       reg_addr;
	logic [31:0]       reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [31:0]       reg_rdata;
	logic              pending;
	logic              emcy_valid;
	dml_rec_t          emcy_record;
	logic              irq;
	int                failures = 0;
	int                samples_checked = 0;
	int                cycles = 0;
	dml_log #(.DEPTH(64)) dml_log_inst (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.ev_valid_in(ev_valid_in), .ev_severity_in(ev_severity_in), .ev_text_in(ev_text_in),
		.ev_pcount_in(ev_pcount_in), .ev_p1_type_in(ev_p1_type_in),
		.ev_p1_value_in(ev_p1_value_in), .ev_p2_type_in(ev_p2_type_in),
		.ev_p2_value_in(ev_p2_value_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
		.pending_out(pending), .emcy_valid_out(emcy_valid), .emcy_record_out(emcy_record),
		.irq_out(irq));
	dml_master_model dml_master_model_inst (.clock_in(clock_in), .reg_rdata_in(reg_rdata),
		.reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr),
		.reg_rd_out(reg_rd));
	// A 40 ns clock.
	always #20 clock_in = ~clock_in;
	// Cycle ceiling that cuts a hang short.
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_sim();
		end
	end
	// ****************************************************************
	// Shared tasks.
	// ****************************************************************
	task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// Reads one register and compares it.
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		dml_master_model_inst.rd(a, d);
		check(what, d, exp);
	endtask
	// Raises one event for one cycle; returns when its results have landed.
	task automatic ev(input logic [3:0] s, input logic [15:0] t, input logic [1:0] n,
		input logic [11:0] t1, input logic [63:0] v1, input logic [11:0] t2);
		@(posedge clock_in);
		ev_valid_in    <= 1'b1;
		ev_severity_in <= s;
		ev_text_in     <= t;
		ev_pcount_in   <= n;
		ev_p1_type_in  <= t1;
		ev_p1_value_in <= v1;
		ev_p2_type_in  <= t2;
		ev_p2_value_in <= 64'h1;
		@(posedge clock_in);
		ev_valid_in <= 1'b0;
		#1;
	endtask
	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic t_idle();
		logic [31:0] a;
		logic [31:0] b;
		rdc(`DML_OFS_MAX, 32'h40, "max");
		dml_master_model_inst.wr(`DML_OFS_NEWEST, 32'h11);
		rdc(`DML_OFS_NEWEST, 32'h00, "newest ro");
		rdc(`DML_OFS_NEWAVAIL, 32'h0, "pending idle");
		rdc(12'h0FC, 32'h0, "unmapped");
		dml_master_model_inst.rd(`DML_OFS_TS_LO, a);
		dml_master_model_inst.rd(`DML_OFS_TS_LO, b);
		check("ts step", b - a, 32'd80);
		rdc(`DML_OFS_TS_HI, 32'h0, "ts high");
		dml_master_model_inst.wr(`DML_OFS_ACK, 32'h07);
		rdc(`DML_OFS_ACK, 32'h07, "ack store");
		$display("test idle done");
	endtask
	task automatic t_first();
		dml_master_model_inst.set_emcy(1'b1);
		dml_master_model_inst.wr(`DML_OFS_IRQ_MASK, 32'h1);
		ev(4'h1, 16'h1234, 2'h2, 12'h007, 64'hA5A55A5A, 12'h001);
		check("emcy pulse", emcy_valid, 1'b1);
		check("head", emcy_record[63:0], 64'h1234_0211_0000E000);
		check("params", emcy_record[255:128],
			{56'h0, 8'h01, 16'h0001, 32'hA5A55A5A, 16'h0007});
		check("pending", pending, 1'b1);
		check("irq raised", irq, 1'b1);
		rdc(`DML_OFS_NEWEST, 32'h06, "newest first");
		dml_master_model_inst.wr(`DML_OFS_IRQ_STAT, 32'h1);
		@(posedge clock_in);
		#1;
		check("irq cleared", irq, 1'b0);
		$display("test first done");
	endtask
	task automatic t_reserved();
		dml_master_model_inst.wr(`DML_OFS_IRQ_MASK, 32'h0);
		dml_master_model_inst.set_emcy(1'b0);
		ev(4'h5, 16'h0BEE, 2'h3, 12'h01B, 64'h1122334455667788, 12'h01B);
		check("no emcy", emcy_valid, 1'b0);
		check("irq masked", irq, 1'b0);
		rdc(12'h824, 32'h0BEE_0112, "clamped flags");
		rdc(12'h830, 32'h7788_001B, "desc64");
		rdc(12'h838, 32'h0000_1122, "param2 dropped");
		dml_master_model_inst.wr(`DML_OFS_IRQ_MASK, 32'h1);
		@(posedge clock_in);
		#1;
		check("irq unmasked", irq, 1'b1);
		dml_master_model_inst.wr(`DML_OFS_IRQ_STAT, 32'h7);
		$display("test reserved done");
	endtask
	task automatic t_wrap();
		logic [63:0] prev;
		dml_master_model_inst.set_emcy(1'b1);
		for (int i = 2; i < 66; i++) begin
			ev(4'h0, i[15:0], 2'h0, 12'h000, 64'h0, 12'h000);
			if (i > 2) check("ts delta", emcy_record[127:64] - prev, 64'd80);
			prev = emcy_record[127:64];
		end
		rdc(`DML_OFS_NEWEST, 32'h07, "newest wrap");
		rdc(`DML_OFS_IRQ_STAT, 32'h3, "wrap status");
		$display("test wrap done");
	endtask
	task automatic t_whole();
		logic [31:0] d;
		logic [31:0] exp;
		dml_master_model_inst.start_whole();
		for (int k = 0; k < 64; k++) begin
			for (int w = 0; w < 8; w++) begin
				dml_master_model_inst.rd(`DML_OFS_WHOLE, d);
				exp = (k < 2) ? k + 64 : k;
				if (w == 0) check("class", d, `DML_CLASS_CODE);
				if (w == 1) check("text", d, {exp[15:0], 16'h0010});
			end
		end
		check("pending cleared", pending, 1'b0);
		rdc(`DML_OFS_IRQ_STAT, 32'h7, "done status");
		rdc(`DML_OFS_WHOLE, 32'h0, "stream over");
		$display("test whole done");
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Main sequence after ten cycles of reset.
	initial begin
		repeat (10) @(posedge clock_in);
		rst_b_in <= 1'b1;
		t_idle();
		t_first();
		t_reserved();
		t_wrap();
		t_whole();
		end_sim();
	end
endmodule
